// ===== pld_cell_pkg.sv
// Constants shared by the macrocell model: array geometry, command codes, timing.
// Assumes one 25 MHz clock and a synchronous programmer command port.
`default_nettype none
package pld_cell_pkg;
	localparam int CELLS = 8;
	localparam int ROWS_PER_CELL = 8;
	localparam int ROWS = CELLS * ROWS_PER_CELL;
	localparam int SIGS = 16;
	localparam int COLS = 2 * SIGS;
	localparam int ROW_W = 6;
	localparam int CMD_W = 4;
	localparam int SIG_BITS = 64;
	localparam int WORD_W = 32;
	localparam int CFG_W = 18;
	// Configuration word layout
	localparam int CFG_POL_LSB = 0;
	localparam int CFG_MODE_LSB = 8;
	localparam int CFG_NOREG = 16;
	localparam int CFG_EMUL = 17;
	localparam logic [CFG_W-1:0] CFG_RESET = 18'h00000;
	// Cells whose pins cannot be dedicated inputs and lose feedback as combinatorial outputs
	localparam int CELL_LOW_FB = 3;
	localparam int CELL_HIGH_FB = 4;
	localparam int ENABLE_ROW = 0;
	// Programmer commands
	localparam logic [CMD_W-1:0] CMD_ERASE = 4'h1;
	localparam logic [CMD_W-1:0] CMD_WR_ROW = 4'h2;
	localparam logic [CMD_W-1:0] CMD_RD_ROW = 4'h3;
	localparam logic [CMD_W-1:0] CMD_WR_CFG = 4'h4;
	localparam logic [CMD_W-1:0] CMD_RD_CFG = 4'h5;
	localparam logic [CMD_W-1:0] CMD_WR_SIG = 4'h6;
	localparam logic [CMD_W-1:0] CMD_RD_SIG = 4'h7;
	localparam logic [CMD_W-1:0] CMD_SECURE = 4'h8;
	localparam logic [WORD_W-1:0] WORD_ZERO = 32'h00000000;
	// Standby entry after inputs hold still this long
	localparam int CLK_PERIOD_NS = 40;
	localparam int STANDBY_NS = 50;
	localparam int STANDBY_CYC = (STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_W = 4;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ERASE = 3'b010,
		ST_DONE = 3'b100
	} prog_state_t;
endpackage : pld_cell_pkg
`default_nettype wire

// ===== pld_macrocell_behaviour.sv
// Eight output cells of a sum-of-products logic device plus its programmer port.
// Assumes pins arrive asynchronously; the device clock pin is sampled, not used as clock.
// Behaviour
// - Polarity bit XORs each cell's sum.
// - Pins 15/16 combinatorial output: no feedback.
// - Pins 15/16 dedicated input is invalid.
// - Power-up clears all cell flip-flops.
// - Registered pins read high after power-up.
// - Preload loads registers from output pins.
// - Preload still works when secured.
// - Secured: refuse readback, programming, verification.
// - Security cleared only by full array erase.
// - Sixty-four bit user signature store.
// - Signature readable regardless of security.
// - Zero-power variant idles into standby.
// - Outputs hold their values in standby.
// - Any input change wakes, no slowdown.
// - Slow variant: clock alone does not wake.
// - Unused product terms disabled on zero-power.
// - Register captures sum; feedback is inverted.
// - Output enable follows cell mode.
// - Combinatorial I/O: seven terms, first enables.
// - Empty term high; true plus complement low.
`timescale 1ns/10ps
`default_nettype none
module pld_macrocell_behaviour #(
	parameter bit ZERO_POWER = 1'b1,
	parameter bit CLOCK_FREE_RUN = 1'b1
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] in_pin,
	input wire logic clk_pin,
	input wire logic oe_n_pin,
	input wire logic [7:0] io_in,
	input wire logic preload,
	input wire logic cmd_valid,
	input wire logic [pld_cell_pkg::CMD_W-1:0] cmd,
	input wire logic [pld_cell_pkg::ROW_W-1:0] cmd_addr,
	input wire logic [pld_cell_pkg::WORD_W-1:0] cmd_wdata,
	output logic [7:0] io_out,
	output logic [7:0] io_oe_n,
	output logic [pld_cell_pkg::WORD_W-1:0] rdata,
	output logic ack,
	output logic refused,
	output logic busy,
	output logic standby,
	output logic cfg_invalid,
	output logic [pld_cell_pkg::ROWS-1:0] pterm_off
);
	localparam int NS = 18;

	// Product term: disconnected columns are true, so an empty term is high
	function automatic logic eval_term(input logic [pld_cell_pkg::COLS-1:0] conn,
			input logic [pld_cell_pkg::COLS-1:0] cols);
		eval_term = &(~conn | cols);
	endfunction : eval_term

	// Term programmed with both true and complement of some input
	function automatic logic term_unused(input logic [pld_cell_pkg::COLS-1:0] conn);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < pld_cell_pkg::SIGS; i++) begin
			hit = hit | (conn[2*i] & conn[2*i+1]);
		end
		term_unused = hit;
	endfunction : term_unused

	logic [NS-1:0] s1_ff, s2_ff, s3_ff;
	logic [pld_cell_pkg::COLS-1:0] fuse_ff [pld_cell_pkg::ROWS];
	logic [pld_cell_pkg::CFG_W-1:0] cfg_ff;
	logic [pld_cell_pkg::SIG_BITS-1:0] sig_ff;
	logic secure_ff;
	logic [7:0] q_ff;
	logic [7:0] io_out_ff, io_oe_n_ff;
	logic [pld_cell_pkg::WORD_W-1:0] rdata_ff;
	logic ack_ff, refused_ff, standby_ff, cfg_invalid_ff, busy_ff;
	logic [pld_cell_pkg::ROWS-1:0] pterm_off_ff;
	logic [pld_cell_pkg::IDLE_W-1:0] idle_ff;
	logic [pld_cell_pkg::ROW_W-1:0] erase_row_ff;
	pld_cell_pkg::prog_state_t state_ff;

	// Synchronised pins: first stage is only read by the second
	wire [7:0] in_s = s2_ff[7:0];
	wire [7:0] io_s = s2_ff[15:8];
	wire clkp_s = s2_ff[16];
	wire oe_n_s = s2_ff[17];
	wire clk_rise = s2_ff[16] & ~s3_ff[16];
	wire [7:0] pol = cfg_ff[pld_cell_pkg::CFG_POL_LSB +: 8];
	wire [7:0] mode = cfg_ff[pld_cell_pkg::CFG_MODE_LSB +: 8];
	wire noreg = cfg_ff[pld_cell_pkg::CFG_NOREG];
	wire emul = cfg_ff[pld_cell_pkg::CFG_EMUL];
	wire [7:0] is_reg = {8{emul & ~noreg}} & ~mode;
	wire [7:0] is_cio = {8{emul}} & mode;
	wire [7:0] is_cout = {8{~emul}} & ~mode;
	wire [7:0] is_din = {8{~emul}} & mode;
	wire bad_cfg = is_din[pld_cell_pkg::CELL_LOW_FB] | is_din[pld_cell_pkg::CELL_HIGH_FB];

	logic [7:0] fb;
	logic [pld_cell_pkg::COLS-1:0] cols;
	logic [pld_cell_pkg::ROWS-1:0] term, unused;
	logic [7:0] sum, en_term;
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			if (is_reg[k]) begin
				fb[k] = ~q_ff[k];
			end else if (is_din[k]) begin
				if (k == 0) begin
					fb[k] = oe_n_s;
				end else if (k == 7) begin
					fb[k] = clkp_s;
				end else begin
					fb[k] = io_s[k+1];
				end
			end else if (is_cout[k] && (k == pld_cell_pkg::CELL_LOW_FB ||
					k == pld_cell_pkg::CELL_HIGH_FB)) begin
				fb[k] = 1'b0;
			end else begin
				fb[k] = io_s[k];
			end
		end
		for (int i = 0; i < 8; i++) begin
			cols[2*i] = in_s[i];
			cols[2*i+1] = ~in_s[i];
			cols[2*i+16] = fb[i];
			cols[2*i+17] = ~fb[i];
		end
		for (int r = 0; r < pld_cell_pkg::ROWS; r++) begin
			unused[r] = term_unused(fuse_ff[r]);
			// Disabled terms are forced low, the value they would give anyway
			term[r] = (ZERO_POWER && unused[r]) ? 1'b0 : eval_term(fuse_ff[r], cols);
		end
		for (int k = 0; k < 8; k++) begin
			sum[k] = 1'b0;
			for (int j = 0; j < pld_cell_pkg::ROWS_PER_CELL; j++) begin
				if (!(is_cio[k] && j == pld_cell_pkg::ENABLE_ROW)) begin
					sum[k] = sum[k] | term[k*pld_cell_pkg::ROWS_PER_CELL+j];
				end
			end
			en_term[k] = term[k*pld_cell_pkg::ROWS_PER_CELL+pld_cell_pkg::ENABLE_ROW];
		end
	end

	// Registers invert into the pin, so a cleared flip-flop shows high
	wire [7:0] nxt_q = preload ? ~io_s : (clk_rise ? ((sum ^ pol) & is_reg | q_ff & ~is_reg) : q_ff);
	wire [7:0] comb_pin = sum ^ ~pol;
	wire [7:0] nxt_io_out = (is_reg & ~q_ff) | (~is_reg & comb_pin);
	wire [7:0] drive = (is_reg & {8{~oe_n_s}}) | (is_cio & en_term) | is_cout;
	wire [7:0] nxt_io_oe_n = ~(drive & {8{~bad_cfg}});

	// Activity for standby; a free-running clock pin alone is not activity
	wire [NS-1:0] act_mask = CLOCK_FREE_RUN ? {1'b1, 1'b0, 16'hFFFF} : {1'b1, 1'b1, 16'hFFFF};
	wire activity = |((s2_ff ^ s3_ff) & act_mask);
	wire idle_full = idle_ff == pld_cell_pkg::IDLE_W'(pld_cell_pkg::STANDBY_CYC);
	wire [pld_cell_pkg::IDLE_W-1:0] nxt_idle = activity ? '0 :
		(idle_full ? idle_ff : idle_ff + pld_cell_pkg::IDLE_W'(1));
	wire nxt_standby = ZERO_POWER && !activity && idle_full;

	// Programmer command decode
	wire take = cmd_valid && state_ff == pld_cell_pkg::ST_IDLE;
	wire c_erase = take && cmd == pld_cell_pkg::CMD_ERASE;
	wire c_wrow = take && cmd == pld_cell_pkg::CMD_WR_ROW;
	wire c_rrow = take && cmd == pld_cell_pkg::CMD_RD_ROW;
	wire c_wcfg = take && cmd == pld_cell_pkg::CMD_WR_CFG;
	wire c_rcfg = take && cmd == pld_cell_pkg::CMD_RD_CFG;
	wire c_wsig = take && cmd == pld_cell_pkg::CMD_WR_SIG;
	wire c_rsig = take && cmd == pld_cell_pkg::CMD_RD_SIG;
	wire c_sec = take && cmd == pld_cell_pkg::CMD_SECURE;
	wire c_known = c_erase | c_wrow | c_rrow | c_wcfg | c_rcfg | c_wsig | c_rsig | c_sec;
	wire guarded = c_wrow | c_rrow | c_wcfg | c_rcfg | c_wsig | c_sec;
	wire deny = (secure_ff && guarded) || (take && !c_known);
	wire ok = take && !deny;
	wire last_row = erase_row_ff == pld_cell_pkg::ROW_W'(pld_cell_pkg::ROWS - 1);
	wire sig_hi = cmd_addr[0];
	wire [pld_cell_pkg::WORD_W-1:0] sig_word = sig_hi ? sig_ff[63:32] : sig_ff[31:0];
	wire [pld_cell_pkg::WORD_W-1:0] nxt_rdata =
		(ok && c_rrow) ? fuse_ff[cmd_addr] :
		(ok && c_rcfg) ? pld_cell_pkg::WORD_W'(cfg_ff) :
		(ok && c_rsig) ? sig_word : rdata_ff;

	pld_cell_pkg::prog_state_t nxt_state;
	always_comb begin
		case (state_ff)
			pld_cell_pkg::ST_IDLE: begin
				nxt_state = c_erase ? pld_cell_pkg::ST_ERASE : pld_cell_pkg::ST_IDLE;
			end
			pld_cell_pkg::ST_ERASE: begin
				nxt_state = last_row ? pld_cell_pkg::ST_DONE : pld_cell_pkg::ST_ERASE;
			end
			default: begin
				nxt_state = pld_cell_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= {oe_n_pin, clk_pin, io_in, in_pin};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Erase walks one row per cycle; the array starts erased (all terms high)
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int r = 0; r < pld_cell_pkg::ROWS; r++) begin
				fuse_ff[r] <= '0;
			end
		end else if (state_ff == pld_cell_pkg::ST_ERASE) begin
			fuse_ff[erase_row_ff] <= '0;
		end else if (ok && c_wrow) begin
			fuse_ff[cmd_addr] <= cmd_wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_ff <= pld_cell_pkg::CFG_RESET;
			sig_ff <= '0;
			secure_ff <= 1'b0;
		end else begin
			if (state_ff == pld_cell_pkg::ST_ERASE && last_row) begin
				cfg_ff <= pld_cell_pkg::CFG_RESET;
				secure_ff <= 1'b0;
			end else if (ok && c_sec) begin
				secure_ff <= 1'b1;
			end else if (ok && c_wcfg) begin
				cfg_ff <= cmd_wdata[pld_cell_pkg::CFG_W-1:0];
			end
			if (ok && c_wsig && sig_hi) begin
				sig_ff[63:32] <= cmd_wdata;
			end else if (ok && c_wsig) begin
				sig_ff[31:0] <= cmd_wdata;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= pld_cell_pkg::ST_IDLE;
			erase_row_ff <= '0;
			ack_ff <= 1'b0;
			refused_ff <= 1'b0;
			busy_ff <= 1'b0;
			rdata_ff <= pld_cell_pkg::WORD_ZERO;
		end else begin
			state_ff <= nxt_state;
			busy_ff <= nxt_state != pld_cell_pkg::ST_IDLE;
			erase_row_ff <= (state_ff == pld_cell_pkg::ST_ERASE) ? erase_row_ff + 1'b1 : '0;
			ack_ff <= (ok && !c_erase) || state_ff == pld_cell_pkg::ST_DONE;
			refused_ff <= take && deny;
			rdata_ff <= nxt_rdata;
		end
	end

	// Standby only flags power state; logic keeps running unchanged
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q_ff <= 8'h00;
			io_out_ff <= 8'h00;
			io_oe_n_ff <= 8'hFF;
			idle_ff <= '0;
			standby_ff <= 1'b0;
			cfg_invalid_ff <= 1'b0;
			pterm_off_ff <= '0;
		end else begin
			q_ff <= nxt_q;
			io_out_ff <= nxt_io_out;
			io_oe_n_ff <= nxt_io_oe_n;
			idle_ff <= nxt_idle;
			standby_ff <= nxt_standby;
			cfg_invalid_ff <= bad_cfg;
			pterm_off_ff <= ZERO_POWER ? unused : '0;
		end
	end
	assign io_out = io_out_ff;
	assign io_oe_n = io_oe_n_ff;
	assign rdata = rdata_ff;
	assign ack = ack_ff;
	assign refused = refused_ff;
	assign busy = busy_ff;
	assign standby = standby_ff;
	assign cfg_invalid = cfg_invalid_ff;
	assign pterm_off = pterm_off_ff;

	sequence sec_cmd;
		cmd_valid && state_ff == pld_cell_pkg::ST_IDLE && secure_ff &&
			(cmd == pld_cell_pkg::CMD_RD_ROW || cmd == pld_cell_pkg::CMD_WR_ROW);
	endsequence
	sequence sig_rd;
		cmd_valid && state_ff == pld_cell_pkg::ST_IDLE && cmd == pld_cell_pkg::CMD_RD_SIG;
	endsequence

	a_pol_comb: assert property (@(posedge clk) disable iff (!nrst)
		is_cout[1] ##1 1'b1 |-> io_out[1] == $past(sum[1] ^ ~pol[1]))
		else $error("comb output polarity wrong");
	a_fb_cut: assert property (@(posedge clk) disable iff (!nrst)
		is_cout[pld_cell_pkg::CELL_LOW_FB] |-> !fb[pld_cell_pkg::CELL_LOW_FB])
		else $error("feedback present on restricted cell");
	a_bad_din: assert property (@(posedge clk) disable iff (!nrst)
		bad_cfg |=> io_oe_n == 8'hFF && cfg_invalid)
		else $error("invalid dedicated input not flagged");
	a_reg_high: assert property (@(posedge clk) disable iff (!nrst)
		is_reg[0] && !q_ff[0] |=> io_out[0])
		else $error("registered pin not high while flop clear");
	a_preload_load: assert property (@(posedge clk) disable iff (!nrst)
		preload |=> q_ff == ~$past(io_s))
		else $error("preload did not load pins");
	a_secure_deny: assert property (@(posedge clk) disable iff (!nrst)
		sec_cmd |=> refused && !ack)
		else $error("secured access not refused");
	a_secure_keep: assert property (@(posedge clk) disable iff (!nrst)
		secure_ff && state_ff != pld_cell_pkg::ST_ERASE |=> secure_ff)
		else $error("security cleared without erase");
	a_sig_read: assert property (@(posedge clk) disable iff (!nrst)
		sig_rd |=> ack && !refused)
		else $error("signature read refused");
	a_standby_wake: assert property (@(posedge clk) disable iff (!nrst)
		activity |=> !standby)
		else $error("standby kept after input change");
	a_standby_hold: assert property (@(posedge clk) disable iff (!nrst)
		standby && !preload && !clk_rise && !busy && !cmd_valid ##2 standby |-> $stable(io_out))
		else $error("output moved in standby");
	a_reg_capture: assert property (@(posedge clk) disable iff (!nrst)
		clk_rise && !preload && is_reg[2] |=> q_ff[2] == $past(sum[2] ^ pol[2]))
		else $error("register missed clock pin edge");
	a_erase_len: assert property (@(posedge clk) disable iff (!nrst)
		$rose(state_ff == pld_cell_pkg::ST_ERASE) |-> ##[63:64] state_ff == pld_cell_pkg::ST_DONE)
		else $error("erase length wrong");
endmodule : pld_macrocell_behaviour
`default_nettype wire

// ===== pld_board_model.sv
// Board around the logic device: resolves each cell pin from device and board drivers.
// Assumes the board only drives a pin while the device has released it.
`timescale 1ns/10ps
`default_nettype none
module pld_board_model (
	input wire logic clk,
	input wire logic [7:0] io_out,
	input wire logic [7:0] io_oe_n,
	input wire logic [7:0] drive_en,
	input wire logic [7:0] drive_val,
	output logic [7:0] io_in
);
	// A floating pin shows a changing pattern so a stale value never passes
	logic [7:0] float_ff = 8'h5A;
	always @(posedge clk) begin
		float_ff <= ~float_ff;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			io_in[i] = !io_oe_n[i] ? io_out[i] : (drive_en[i] ? drive_val[i] : float_ff[i]);
		end
	end
endmodule : pld_board_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the macrocell block: programmer commands and pin behaviour.
// Assumes the board model resolves the pins; inputs change on the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic nrst, clk_pin, oe_n_pin, preload, cmd_valid, ack, refused, busy, standby, cfg_invalid;
	logic [7:0] in_pin, io_in, io_out, io_oe_n, drive_en, drive_val, v, d;
	logic [3:0] cmd;
	logic [5:0] cmd_addr;
	logic [31:0] cmd_wdata, rdata, s0, s1, p;
	logic [63:0] pterm_off;
	logic got_ack, got_ref, got_busy;
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	pld_macrocell_behaviour dut_u (.clk(clk), .nrst(nrst), .in_pin(in_pin), .clk_pin(clk_pin),
		.oe_n_pin(oe_n_pin), .io_in(io_in), .preload(preload), .cmd_valid(cmd_valid),
		.cmd(cmd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .io_out(io_out),
		.io_oe_n(io_oe_n), .rdata(rdata), .ack(ack), .refused(refused), .busy(busy),
		.standby(standby), .cfg_invalid(cfg_invalid), .pterm_off(pterm_off));
	pld_board_model board_u (.clk(clk), .io_out(io_out), .io_oe_n(io_oe_n),
		.drive_en(drive_en), .drive_val(drive_val), .io_in(io_in));
	always #20 clk = ~clk;
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	// Generous ceiling: the whole sequence needs well under 3000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_cyc
	// One programmer command; waits out busy, then for the ack or refusal pulse
	task automatic do_cmd(input logic [3:0] c, input logic [5:0] a, input logic [31:0] w);
		int i;
		i = 0;
		while (busy !== 1'b0 && i < 200) begin
			@(negedge clk);
			i++;
		end
		cmd_valid = 1'b1;
		cmd = c;
		cmd_addr = a;
		cmd_wdata = w;
		@(negedge clk);
		cmd_valid = 1'b0;
		got_ack = 1'b0;
		got_ref = 1'b0;
		got_busy = 1'b0;
		for (i = 0; i < 100 && !got_ack && !got_ref; i++) begin
			got_ack = (ack === 1'b1);
			got_ref = (refused === 1'b1);
			got_busy = got_busy | (busy === 1'b1);
			if (!got_ack && !got_ref) @(negedge clk);
		end
		// Gap so the next call never raises cmd_valid in this same time step
		@(negedge clk);
	endtask : do_cmd
	task automatic fill_rows(input logic [31:0] w);
		for (int r = 0; r < pld_cell_pkg::ROWS; r++) begin
			do_cmd(pld_cell_pkg::CMD_WR_ROW, r[5:0], w);
		end
	endtask : fill_rows
	function automatic logic [31:0] comb_cfg(input logic [7:0] pol);
		return (32'h1 << pld_cell_pkg::CFG_NOREG) | {24'h000000, pol};
	endfunction : comb_cfg
	function automatic logic [7:0] comb_out(input logic s, input logic [7:0] pol);
		return {8{s}} ^ ~pol;
	endfunction : comb_out
	initial begin
		{nrst, clk_pin, oe_n_pin, preload, cmd_valid} = 5'h00;
		{in_pin, drive_en, drive_val, cmd, cmd_addr, cmd_wdata} = 66'h0;
		void'($urandom(81));
		wait_cyc(1);
		check({24'h0, io_oe_n}, 32'hFF);
		check({24'h0, io_out}, 32'h00);
		wait_cyc(1);
		nrst = 1'b1;
		wait_cyc(6);
		check({24'h0, io_out}, 32'h00);
		check({24'h0, io_oe_n}, 32'h00);
		$display("test power_up done");
		do_cmd(pld_cell_pkg::CMD_ERASE, 6'h00, 32'h0);
		check({31'h0, got_ack}, 32'h1);
		check({31'h0, got_busy}, 32'h1);
		// Every term wired to a signal and its complement: sum is low
		fill_rows(32'h00000003);
		p = {24'h0, 8'($urandom)};
		do_cmd(pld_cell_pkg::CMD_WR_CFG, 6'h00, comb_cfg(p[7:0]));
		wait_cyc(6);
		check({24'h0, io_out}, {24'h0, comb_out(1'b0, p[7:0])});
		check(pterm_off[31:0], 32'hFFFFFFFF);
		check(pterm_off[63:32], 32'hFFFFFFFF);
		fill_rows(32'h00000001);
		for (int k = 0; k < 8; k++) begin
			p = {24'h0, 8'($urandom)};
			in_pin = 8'($urandom);
			do_cmd(pld_cell_pkg::CMD_WR_CFG, 6'h00, comb_cfg(p[7:0]));
			wait_cyc(6);
			check({24'h0, io_out}, {24'h0, comb_out(in_pin[0], p[7:0])});
			do_cmd(pld_cell_pkg::CMD_RD_ROW, 6'($urandom), 32'h0);
			check(rdata, 32'h00000001);
			do_cmd(pld_cell_pkg::CMD_RD_CFG, 6'h00, 32'h0);
			check({14'h0, rdata[17:0]}, comb_cfg(p[7:0]));
		end
		check(pterm_off[31:0], 32'h00000000);
		$display("test polarity done");
		do_cmd(pld_cell_pkg::CMD_WR_CFG, 6'h00, comb_cfg(8'hFF) | 32'h00000800);
		wait_cyc(6);
		check({31'h0, cfg_invalid}, 32'h1);
		check({24'h0, io_oe_n}, 32'hFF);
		do_cmd(pld_cell_pkg::CMD_WR_CFG, 6'h00, comb_cfg(8'hFF) | 32'h00000200);
		wait_cyc(6);
		check({31'h0, cfg_invalid}, 32'h0);
		check({24'h0, io_oe_n}, 32'h02);
		// Cell 0 enable term always high; its other seven terms follow in_pin[0]
		do_cmd(pld_cell_pkg::CMD_WR_ROW, 6'h00, 32'h0);
		for (int k = 0; k < 2; k++) begin
			in_pin = {7'h00, k[0]};
			do_cmd(pld_cell_pkg::CMD_WR_CFG, 6'h00, 32'h3FFFF);
			wait_cyc(6);
			check({24'h0, io_out}, {24'h0, {8{k[0]}}});
			check({24'h0, io_oe_n}, {24'h0, {7{~k[0]}}, 1'b0});
		end
		do_cmd(pld_cell_pkg::CMD_WR_ROW, 6'h00, 32'h1);
		$display("test modes done");
		do_cmd(pld_cell_pkg::CMD_WR_CFG, 6'h00, (32'h1 << pld_cell_pkg::CFG_EMUL) | 32'hFF);
		wait_cyc(6);
		check({24'h0, io_out}, 32'hFF);
		v = 8'($urandom);
		in_pin = v;
		clk_pin = 1'b1;
		wait_cyc(6);
		clk_pin = 1'b0;
		wait_cyc(6);
		check({24'h0, io_out}, {24'h0, {8{v[0]}}});
		oe_n_pin = 1'b1;
		wait_cyc(6);
		check({24'h0, io_oe_n}, 32'hFF);
		// Preload drives the pins from the board while the device is released
		for (int k = 0; k < 2; k++) begin
			d = 8'($urandom);
			drive_en = 8'hFF;
			drive_val = d;
			preload = 1'b1;
			wait_cyc(6);
			preload = 1'b0;
			drive_en = 8'h00;
			oe_n_pin = 1'b0;
			wait_cyc(6);
			check({24'h0, io_out}, {24'h0, d});
			oe_n_pin = 1'b1;
			if (k == 0) begin
				s0 = $urandom;
				s1 = $urandom;
				do_cmd(pld_cell_pkg::CMD_WR_SIG, 6'h00, s0);
				do_cmd(pld_cell_pkg::CMD_WR_SIG, 6'h01, s1);
				do_cmd(pld_cell_pkg::CMD_SECURE, 6'h00, 32'h0);
				check({31'h0, got_ack}, 32'h1);
			end
		end
		$display("test register done");
		for (int c = 2; c <= 8; c++) begin
			if (c == 6) c = 8;
			do_cmd(c[3:0], 6'h01, 32'hFFFFFFFF);
			check({31'h0, got_ref}, 32'h1);
		end
		do_cmd(4'hF, 6'h00, 32'h0);
		check({31'h0, got_ref}, 32'h1);
		do_cmd(pld_cell_pkg::CMD_RD_SIG, 6'h00, 32'h0);
		check(rdata, s0);
		do_cmd(pld_cell_pkg::CMD_RD_SIG, 6'h01, 32'h0);
		check(rdata, s1);
		oe_n_pin = 1'b0;
		do_cmd(pld_cell_pkg::CMD_ERASE, 6'h00, 32'h0);
		check({31'h0, got_ack}, 32'h1);
		do_cmd(pld_cell_pkg::CMD_RD_ROW, 6'h05, 32'h0);
		check(rdata, 32'h0);
		check({31'h0, got_busy}, 32'h0);
		$display("test security done");
		// Erased array, cfg 0: outputs settle low and stay put in standby
		wait_cyc(8);
		check({31'h0, standby}, 32'h1);
		check({24'h0, io_out}, 32'h00);
		repeat (4) begin
			clk_pin = ~clk_pin;
			wait_cyc(2);
		end
		check({31'h0, standby}, 32'h1);
		in_pin = ~in_pin;
		wait_cyc(4);
		check({31'h0, standby}, 32'h0);
		check({24'h0, io_out}, 32'h00);
		$display("test standby done");
		final_report();
	end
endmodule : tb_top
`default_nettype wire
